/* File: verification/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Register port, driven by the bench
  logic        sys_clk  = 1'b0;
  logic        rst_b    = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wrData   = 32'h0;
  logic        wrStrobe = 1'b0;
  logic        rdStrobe = 1'b0;
  // Observed outputs
  logic [31:0] rdData;
  logic        lane0SlewSelect, lane1SlewSelect, lane2SlewSelect, lane3SlewSelect;
  logic        clkaSlewSelect, clkbSlewSelect;
  logic [1:0]  lane0DriveSelect, lane1DriveSelect, lane2DriveSelect, lane3DriveSelect;
  logic [1:0]  clkaDriveSelect, clkbDriveSelect;
  // Bench bookkeeping
  int          errCount  = 0;
  int          checked   = 0;
  int          cycles    = 0;
  logic [31:0] model [2];
  logic [31:0] rdQ [$];
  logic [63:0] padQ [$];
  logic [63:0] padExp;
  logic        wasWr     = 1'b0;
  logic        wasRd     = 1'b0;
  logic [31:0] seed      = 32'h2768_0579;
  logic [7:0]  addrTbl [4] = '{8'h00, 8'h04, 8'h08, 8'h05};
  localparam logic [63:0] RST_PADS = {32'h1111_1111, 32'h0000_1111};

  tpc_trace_pad_regs tpc_trace_pad_regs_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .lane0SlewSelect(lane0SlewSelect), .lane0DriveSelect(lane0DriveSelect),
    .lane1SlewSelect(lane1SlewSelect), .lane1DriveSelect(lane1DriveSelect),
    .lane2SlewSelect(lane2SlewSelect), .lane2DriveSelect(lane2DriveSelect),
    .lane3SlewSelect(lane3SlewSelect), .lane3DriveSelect(lane3DriveSelect),
    .clkaSlewSelect(clkaSlewSelect), .clkaDriveSelect(clkaDriveSelect),
    .clkbSlewSelect(clkbSlewSelect), .clkbDriveSelect(clkbDriveSelect)
  );

  // Random source, a plain shift register so runs repeat exactly
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Pad outputs packed into register layout, so one compare covers every field
  function automatic logic [63:0] padsNow();
    return {3'h0, lane3SlewSelect, 2'h0, lane3DriveSelect, 3'h0, lane2SlewSelect, 2'h0, lane2DriveSelect,
            3'h0, lane1SlewSelect, 2'h0, lane1DriveSelect, 3'h0, lane0SlewSelect, 2'h0, lane0DriveSelect,
            19'h0, clkbSlewSelect, 2'h0, clkbDriveSelect, 3'h0, clkaSlewSelect, 2'h0, clkaDriveSelect};
  endfunction : padsNow

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (errCount == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic resetModel();
    model[0] = 32'h1111_1111;
    model[1] = 32'h0000_1111;
  endtask : resetModel

  // One bus access; the expected outcome is noted as it is issued
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic hit;
    logic [31:0] mask;
    hit = (a == 8'h00) || (a == 8'h04);
    mask = (a == 8'h00) ? 32'h1313_1313 : 32'h0000_1313;
    @(posedge sys_clk);
    wrStrobe <= wr;
    rdStrobe <= !wr;
    addr <= a;
    wrData <= d;
    if (wr && hit) model[a[2]] = d & mask;
    if (wr) padQ.push_back({model[0], model[1]});
    else rdQ.push_back(hit ? model[a[2]] : 32'h0);
  endtask : acc

  task automatic idle();
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
  endtask : idle

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Note which edges took a request, and cut a hang short
  always @(posedge sys_clk) begin
    wasWr <= wrStrobe && rst_b;
    wasRd <= rdStrobe && rst_b;
    cycles++;
    if (cycles > 3000) begin
      errCount++;
      results();
    end
  end

  // Compare away from the edge, once everything has settled
  always @(negedge sys_clk) begin
    if (!rst_b) begin
      padExp = RST_PADS;
      rdQ.delete();
      padQ.delete();
    end else begin
      if (wasWr && padQ.size() > 0) padExp = padQ.pop_front();
      if (wasRd && rdQ.size() > 0) chk({32'h0, rdData}, {32'h0, rdQ.pop_front()});
      else chk({32'h0, rdData}, 64'h0);
      chk(padsNow(), padExp);
    end
  end

  initial begin
    resetModel();
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b1, 8'h00, 32'hFFFF_FFFF);
    acc(1'b1, 8'h04, 32'hFFFF_FFFF);
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b0, 8'h04, 32'h0);
    // Every drive code on every pad, with all slews fast
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h00, {4{6'h00, c[1:0]}});
      acc(1'b1, 8'h04, {16'h0000, {2{6'h00, c[1:0]}}});
      acc(1'b0, 8'h04, 32'h0);
    end
    // Random mix, back to back, unmapped addresses included
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      acc(seed[31], addrTbl[seed[1:0]], lfsr(seed));
    end
    // Reset in mid-run must restore every field
    acc(1'b1, 8'h00, 32'h0);
    acc(1'b1, 8'h04, 32'h0);
    idle();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    resetModel();
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b0, 8'h04, 32'h0);
    idle();
    repeat (3) @(posedge sys_clk);
    results();
  end
endmodule : tb

`default_nettype wire

/* File: verilog/tpc_addr_decode.sv */
`default_nettype none

module tpc_addr_decode (
  // Bus address
  input  wire logic [tpc_pkg::ADDR_W-1:0] addr,
  // Register selects
  output logic                            selData,
  output logic                            selClock
);

  // Full compare so aliases of a register never hit
  function automatic logic hit(input logic [tpc_pkg::ADDR_W-1:0] a,
                               input logic [tpc_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // One select per register
  assign selData  = hit(addr, tpc_pkg::OFF_DATA_PAD);
  assign selClock = hit(addr, tpc_pkg::OFF_CLOCK_PAD);

endmodule : tpc_addr_decode

`default_nettype wire

/* File: verilog/tpc_pad_setting.sv */
`default_nettype none

module tpc_pad_setting (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Load from the register bus
  input  wire logic              load,
  input  wire logic              slewIn,
  input  wire logic [1:0]        driveIn,
  // Held pad setting
  output tpc_pkg::tpc_slew_type  slew,
  output tpc_pkg::tpc_drive_type drive
);

  // Slew bit holds until software rewrites it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slew <= tpc_pkg::SLEW_RST;
    end else if (load) begin
      slew <= tpc_pkg::tpc_slew_type'(slewIn);
    end
  end

  // Drive code is stored as written, every code is legal
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive <= tpc_pkg::DRIVE_RST;
    end else if (load) begin
      drive <= tpc_pkg::tpc_drive_type'(driveIn);
    end
  end

endmodule : tpc_pad_setting

`default_nettype wire

/* File: verilog/tpc_pkg.sv */
`default_nettype none

package tpc_pkg;

  // Register bus geometry
  localparam int             DATA_W        = 32;
  localparam int             ADDR_W        = 8;

  // Register offsets (byte addresses)
  localparam logic [7:0]     OFF_DATA_PAD  = 8'h00;
  localparam logic [7:0]     OFF_CLOCK_PAD = 8'h04;

  // Field layout: each pad group owns one byte of a register
  localparam int             LANES         = 4;
  localparam int             CLOCK_PADS    = 2;
  localparam int             LANE_STRIDE   = 8;
  localparam int             SLEW_POS      = 4;
  localparam int             DRIVE_LSB     = 0;
  localparam int             DRIVE_W       = 2;

  // Clock pads: A in byte 0, B in byte 1
  localparam int             CLKA_INDEX    = 0;
  localparam int             CLKB_INDEX    = 1;

  // Writable bit masks; everything else is reserved
  localparam logic [31:0]    DATA_MASK     = 32'h1313_1313;
  localparam logic [31:0]    CLOCK_MASK    = 32'h0000_1313;

  // Slew selection
  typedef enum logic {
    SLEW_FAST = 1'b0,
    SLEW_SLOW = 1'b1
  } tpc_slew_type;

  // Drive strength code, passed to the pad cell untouched
  typedef enum logic [1:0] {
    DRIVE_2MA  = 2'b00,
    DRIVE_8MA  = 2'b01,
    DRIVE_4MA  = 2'b10,
    DRIVE_12MA = 2'b11
  } tpc_drive_type;

  // Reset values
  localparam tpc_slew_type   SLEW_RST      = SLEW_SLOW;
  localparam tpc_drive_type  DRIVE_RST     = DRIVE_8MA;
  localparam logic [31:0]    DATA_RST      = 32'h1111_1111;
  localparam logic [31:0]    CLOCK_RST     = 32'h0000_1111;

endpackage : tpc_pkg

`default_nettype wire

/* File: verilog/tpc_trace_pad_regs.sv */
// The address map and the strobed register port were left to the implementer.
`default_nettype none

module tpc_trace_pad_regs (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst_b,
  // Register port
  input  wire logic [tpc_pkg::ADDR_W-1:0]      addr,
  input  wire logic [tpc_pkg::DATA_W-1:0]      wrData,
  input  wire logic                            wrStrobe,
  input  wire logic                            rdStrobe,
  output logic      [tpc_pkg::DATA_W-1:0]      rdData,
  // Trace data pads, one lane per byte of trace data
  output logic                                 lane0SlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     lane0DriveSelect,
  output logic                                 lane1SlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     lane1DriveSelect,
  output logic                                 lane2SlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     lane2DriveSelect,
  output logic                                 lane3SlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     lane3DriveSelect,
  // Trace clock pads
  output logic                                 clkaSlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     clkaDriveSelect,
  output logic                                 clkbSlewSelect,
  output logic      [tpc_pkg::DRIVE_W-1:0]     clkbDriveSelect
);

  localparam int PADS = tpc_pkg::LANES + tpc_pkg::CLOCK_PADS;

  // Layout checks: every pad group must fit one byte of the word
  if (tpc_pkg::LANES * tpc_pkg::LANE_STRIDE > tpc_pkg::DATA_W) begin : g_bad_lanes
    $error("Data lanes do not fit the register width");
  end
  if (tpc_pkg::SLEW_POS >= tpc_pkg::LANE_STRIDE) begin : g_bad_slew
    $error("Slew bit lies outside its byte");
  end

  logic                           selData;
  logic                           selClock;
  tpc_pkg::tpc_slew_type          padSlew  [PADS];
  tpc_pkg::tpc_drive_type         padDrive [PADS];
  logic [tpc_pkg::DATA_W-1:0]     dataWord;
  logic [tpc_pkg::DATA_W-1:0]     clockWord;
  logic [tpc_pkg::DATA_W-1:0]     next_rdData;

  // Register select
  tpc_addr_decode u_decode (
    .addr     (addr),
    .selData  (selData),
    .selClock (selClock)
  );

  // Place one pad group into its byte of a register word
  function automatic logic [tpc_pkg::DATA_W-1:0] placeGroup(input logic slew,
                                                            input logic [1:0] drive,
                                                            input int group);
    logic [tpc_pkg::DATA_W-1:0] word;
    word = '0;
    word[group*tpc_pkg::LANE_STRIDE + tpc_pkg::SLEW_POS] = slew;
    word[group*tpc_pkg::LANE_STRIDE + tpc_pkg::DRIVE_LSB +: tpc_pkg::DRIVE_W] = drive;
    placeGroup = word;
  endfunction : placeGroup

  // Pad settings: indices 0..3 are data lanes, then clock A and clock B.
  // No busy or lock state, so a write lands on the next edge whenever it comes.
  for (genvar p = 0; p < PADS; p++) begin : g_pad
    localparam int GRP = (p < tpc_pkg::LANES) ? p : p - tpc_pkg::LANES;
    localparam int BASE = GRP * tpc_pkg::LANE_STRIDE;
    logic load;
    // Lane byte GRP covers trace data bits [8*GRP+7:8*GRP]
    assign load = wrStrobe && ((p < tpc_pkg::LANES) ? selData : selClock);
    tpc_pad_setting u_set (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .load    (load),
      .slewIn  (wrData[BASE + tpc_pkg::SLEW_POS]),
      .driveIn (wrData[BASE + tpc_pkg::DRIVE_LSB +: tpc_pkg::DRIVE_W]),
      .slew    (padSlew[p]),
      .drive   (padDrive[p])
    );
  end

  // Read-back words; reserved positions stay zero by construction
  always_comb begin
    dataWord  = '0;
    clockWord = '0;
    for (int l = 0; l < tpc_pkg::LANES; l++) begin
      dataWord = dataWord | placeGroup(padSlew[l], padDrive[l], l);
    end
    for (int c = 0; c < tpc_pkg::CLOCK_PADS; c++) begin
      clockWord = clockWord | placeGroup(padSlew[tpc_pkg::LANES + c], padDrive[tpc_pkg::LANES + c], c);
    end
  end

  // Read mux; unmapped addresses and idle cycles return zero
  always_comb begin
    next_rdData = '0;
    if (rdStrobe && selData) begin
      next_rdData = dataWord;
    end else if (rdStrobe && selClock) begin
      next_rdData = clockWord;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
    end else begin
      rdData <= next_rdData;
    end
  end

  // Pad outputs come straight from the setting flops, code unchanged
  assign lane0SlewSelect  = padSlew[0];
  assign lane0DriveSelect = padDrive[0];
  assign lane1SlewSelect  = padSlew[1];
  assign lane1DriveSelect = padDrive[1];
  assign lane2SlewSelect  = padSlew[2];
  assign lane2DriveSelect = padDrive[2];
  assign lane3SlewSelect  = padSlew[3];
  assign lane3DriveSelect = padDrive[3];
  assign clkaSlewSelect   = padSlew[tpc_pkg::LANES + tpc_pkg::CLKA_INDEX];
  assign clkaDriveSelect  = padDrive[tpc_pkg::LANES + tpc_pkg::CLKA_INDEX];
  assign clkbSlewSelect   = padSlew[tpc_pkg::LANES + tpc_pkg::CLKB_INDEX];
  assign clkbDriveSelect  = padDrive[tpc_pkg::LANES + tpc_pkg::CLKB_INDEX];

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Bus request shapes
  sequence s_data_write;
    wrStrobe && addr == tpc_pkg::OFF_DATA_PAD;
  endsequence
  sequence s_clock_write;
    wrStrobe && addr == tpc_pkg::OFF_CLOCK_PAD;
  endsequence
  sequence s_data_read;
    rdStrobe && addr == tpc_pkg::OFF_DATA_PAD;
  endsequence
  sequence s_clock_read;
    rdStrobe && addr == tpc_pkg::OFF_CLOCK_PAD;
  endsequence

  // Reset values are visible at the first edge after release
  a_reset_values: assert property (
    $rose(rst_b) |-> dataWord == tpc_pkg::DATA_RST && clockWord == tpc_pkg::CLOCK_RST)
    else $error("Pad registers left reset with wrong values");

  // A data write lands masked on the next edge
  a_data_write_lands: assert property (
    s_data_write |=> dataWord == ($past(wrData) & tpc_pkg::DATA_MASK))
    else $error("Data pad write did not land");

  // A clock write lands masked on the next edge
  a_clock_write_lands: assert property (
    s_clock_write |=> clockWord == ($past(wrData) & tpc_pkg::CLOCK_MASK))
    else $error("Clock pad write did not land");

  // Settings hold without a write to their register
  a_data_holds: assert property (
    !(wrStrobe && selData) |=> $stable(dataWord))
    else $error("Data pad settings changed without a write");
  a_clock_holds: assert property (
    !(wrStrobe && selClock) |=> $stable(clockWord))
    else $error("Clock pad settings changed without a write");

  // Write then read returns the written fields, reserved bits zero
  a_write_read_back: assert property (
    s_data_write ##1 s_data_read |=> rdData == ($past(wrData, 2) & tpc_pkg::DATA_MASK))
    else $error("Read-back differs from the written data fields");

  // Read answer in the following cycle, then zero if no new read
  a_read_answer: assert property (
    s_clock_read ##1 !rdStrobe |-> rdData == $past(clockWord) ##1 rdData == '0)
    else $error("Clock pad read answer wrong or not a single cycle");

  // Idle and unmapped cycles return zero
  a_read_idle_zero: assert property (
    (!rdStrobe || (!selData && !selClock)) |=> rdData == '0)
    else $error("Read data not zero outside a mapped read");

  // Lane 3 pads follow bits 28 and 25:24 of the data word
  a_lane3_pads: assert property (
    s_data_write |=> lane3SlewSelect == $past(wrData[28])
                     && lane3DriveSelect == $past(wrData[25:24]))
    else $error("Lane 3 pad controls do not follow the write");

  // Lane 0 pads follow bits 4 and 1:0 of the data word
  a_lane0_pads: assert property (
    s_data_write |=> lane0SlewSelect == $past(wrData[4])
                     && lane0DriveSelect == $past(wrData[1:0]))
    else $error("Lane 0 pad controls do not follow the write");

  // Clock B pads follow bits 12 and 9:8 of the clock word
  a_clkb_pads: assert property (
    s_clock_write |=> clkbSlewSelect == $past(wrData[12])
                      && clkbDriveSelect == $past(wrData[9:8]))
    else $error("Clock B pad controls do not follow the write");

  // Clock A pads follow bits 4 and 1:0 of the clock word
  a_clka_pads: assert property (
    s_clock_write |=> clkaSlewSelect == $past(wrData[4])
                      && clkaDriveSelect == $past(wrData[1:0]))
    else $error("Clock A pad controls do not follow the write");

  // Reserved bits never appear on the read port
  a_reserved_zero: assert property (
    (rdData & ~tpc_pkg::DATA_MASK) == '0)
    else $error("Reserved bit read as one");

  // Lane 2 pads follow bits 20 and 17:16 of the data word
  a_lane2_pads: assert property (
    s_data_write |=> lane2SlewSelect == $past(wrData[20])
                     && lane2DriveSelect == $past(wrData[17:16]))
    else $error("Lane 2 pad controls do not follow the write");

  // Lane 1 pads follow bits 12 and 9:8 of the data word
  a_lane1_pads: assert property (
    s_data_write |=> lane1SlewSelect == $past(wrData[12])
                     && lane1DriveSelect == $past(wrData[9:8]))
    else $error("Lane 1 pad controls do not follow the write");

  // Every pad leaves reset slow at 8 mA, so the trace lines stay quiet
  // until software has chosen a setting for the board
  a_reset_pads: assert property (
    $rose(rst_b) |-> {lane3SlewSelect, lane2SlewSelect, lane1SlewSelect, lane0SlewSelect,
                      clkbSlewSelect, clkaSlewSelect} == {6{tpc_pkg::SLEW_RST}}
                     && {lane3DriveSelect, lane2DriveSelect, lane1DriveSelect, lane0DriveSelect,
                         clkbDriveSelect, clkaDriveSelect} == {6{tpc_pkg::DRIVE_RST}})
    else $error("Pad controls left reset with wrong values");

  // A data read answers with the word as it stood when the strobe was taken
  a_data_read_answer: assert property (
    s_data_read |=> rdData == $past(dataWord))
    else $error("Data pad read answer wrong");

  // Clock write then read returns the written fields, reserved bits zero
  a_clock_read_back: assert property (
    s_clock_write ##1 s_clock_read |=> rdData == ($past(wrData, 2) & tpc_pkg::CLOCK_MASK))
    else $error("Clock read-back differs from the written fields");

  // Two reads back to back each answer for their own register
  sequence s_read_pair;
    s_data_read ##1 s_clock_read;
  endsequence
  a_read_pair: assert property (
    s_read_pair |-> rdData == $past(dataWord) ##1 rdData == $past(clockWord))
    else $error("Back-to-back reads answered out of turn");

  // Two writes back to back both land; nothing is lost to a busy state
  sequence s_write_pair;
    s_data_write ##1 s_clock_write;
  endsequence
  a_write_pair: assert property (
    s_write_pair |=> dataWord == ($past(wrData, 2) & tpc_pkg::DATA_MASK)
                     && clockWord == ($past(wrData) & tpc_pkg::CLOCK_MASK))
    else $error("Back-to-back writes did not both land");

  // A write to an unmapped address touches nothing; full decode leaves no alias
  sequence s_stray_write;
    wrStrobe && !selData && !selClock;
  endsequence
  a_stray_write: assert property (
    s_stray_write |=> $stable(dataWord) && $stable(clockWord))
    else $error("Write to an unmapped address changed a pad setting");

  // Reserved positions of both stored words stay zero whatever is written
  a_data_reserved: assert property (
    (dataWord & ~tpc_pkg::DATA_MASK) == '0)
    else $error("Reserved data pad bit held a one");
  a_clock_reserved: assert property (
    (clockWord & ~tpc_pkg::CLOCK_MASK) == '0)
    else $error("Reserved clock pad bit held a one");

  // The pads drive what software reads back; no shadow copy may drift apart
  a_pads_match_data: assert property (
    {lane3SlewSelect, lane3DriveSelect, lane2SlewSelect, lane2DriveSelect,
     lane1SlewSelect, lane1DriveSelect, lane0SlewSelect, lane0DriveSelect}
      == {dataWord[28], dataWord[25:24], dataWord[20], dataWord[17:16],
          dataWord[12], dataWord[9:8], dataWord[4], dataWord[1:0]})
    else $error("Data pad controls differ from the data register");
  a_pads_match_clock: assert property (
    {clkbSlewSelect, clkbDriveSelect, clkaSlewSelect, clkaDriveSelect}
      == {clockWord[12], clockWord[9:8], clockWord[4], clockWord[1:0]})
    else $error("Clock pad controls differ from the clock register");

endmodule : tpc_trace_pad_regs

`default_nettype wire
